// [design/bau_alu_top.sv]
`timescale 1ns/1ps
`default_nettype none
module bau_alu_top #(
	parameter int FILE_DEPTH = bau_pkg::FILE_DEPTH
) (
	// clock and reset
	input  wire logic                           mclk,
	input  wire logic                           srst,
	// instruction issue
	input  wire logic                           op_valid,
	input  wire bau_pkg::bau_op_t               op_code,
	input  wire logic [bau_pkg::FADDR_W-1:0]    op_addr,
	input  wire logic                           op_dest,
	input  wire logic [bau_pkg::DATA_W-1:0]     op_lit,
	// register port
	input  wire logic [bau_pkg::BUS_ADDR_W-1:0] bus_addr,
	input  wire logic [bau_pkg::DATA_W-1:0]     bus_wdata,
	input  wire logic                           bus_wr,
	input  wire logic                           bus_rd,
	output logic [bau_pkg::DATA_W-1:0]          bus_rdata,
	// datapath state
	output logic                                op_done,
	output logic [bau_pkg::DATA_W-1:0]          acc_out,
	output logic                                carry_flag,
	output logic                                digit_carry_flag,
	output logic                                zero_flag,
	output logic [bau_pkg::DATA_W-1:0]          port_direction_a,
	output logic [bau_pkg::DATA_W-1:0]          port_direction_b
);
	import bau_pkg::*;

	logic [7:0] file_mem_ff [FILE_DEPTH];
	logic [7:0] acc_ff;
	logic       c_ff;
	logic       dc_ff;
	logic       z_ff;
	logic [7:0] dir_a_ff;
	logic [7:0] dir_b_ff;
	logic [7:0] rdata_ff;
	logic       done_ff;

	logic [7:0] src;
	logic [7:0] res;
	logic       res_valid;
	logic       c_new;
	logic       dc_new;
	logic       z_new;
	logic       upd_c;
	logic       upd_dc;
	logic       upd_z;
	logic       wr_acc;
	logic       wr_file;
	logic       flag_c;
	logic       flag_dc;
	logic       flag_z;
	logic [7:0] status_rd;

	// bus address decoding, shared by the write and read paths
	function automatic logic is_file_addr(input logic [5:0] a);
		return (a[5] == 1'b0);
	endfunction

	function automatic logic [4:0] file_index(input logic [5:0] a);
		return a[4:0];
	endfunction

	// the addressed file register is the source for register operations
	assign src = file_mem_ff[op_addr];

	bau_exec_unit u_exec (
		.op        (op_code),
		.src       (src),
		.acc       (acc_ff),
		.lit       (op_lit),
		.carry_in  (c_ff),
		.res       (res),
		.res_valid (res_valid),
		.c_out     (c_new),
		.dc_out    (dc_new),
		.z_out     (z_new),
		.upd_c     (upd_c),
		.upd_dc    (upd_dc),
		.upd_z     (upd_z)
	);

	// destination steering; the immediate form always lands in acc
	always_comb begin
		wr_acc  = 1'b0;
		wr_file = 1'b0;
		if (op_valid && res_valid) begin
			if (op_code == OP_XOR_IMMEDIATE) begin
				wr_acc = 1'b1;
			end else if (op_dest) begin
				wr_file = 1'b1;
			end else begin
				wr_acc = 1'b1;
			end
		end
	end

	// file registers: an instruction write beats a bus write
	generate
		for (genvar g = 0; g < FILE_DEPTH; g++) begin : g_file
			always_ff @(posedge mclk) begin
				if (srst) begin
					file_mem_ff[g] <= FILE_RST;
				end else if (wr_file && op_addr == 5'(g)) begin
					file_mem_ff[g] <= res;
				end else if (bus_wr && is_file_addr(bus_addr)
					&& file_index(bus_addr) == 5'(g)) begin
					file_mem_ff[g] <= bus_wdata;
				end
			end
		end
	endgenerate

	// accumulator
	always_ff @(posedge mclk) begin
		if (srst) begin
			acc_ff <= ACC_RST;
		end else if (wr_acc) begin
			acc_ff <= res;
		end else if (bus_wr && bus_addr == OFF_ACC) begin
			acc_ff <= bus_wdata;
		end
	end

	// status flags: a hardware update wins over a software write
	assign flag_c  = bus_wdata[STAT_C_BIT];
	assign flag_dc = bus_wdata[STAT_DC_BIT];
	assign flag_z  = bus_wdata[STAT_Z_BIT];

	always_ff @(posedge mclk) begin
		if (srst) begin
			c_ff <= FLAG_RST;
		end else if (op_valid && upd_c) begin
			c_ff <= c_new;
		end else if (bus_wr && bus_addr == OFF_STATUS) begin
			c_ff <= flag_c;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			dc_ff <= FLAG_RST;
		end else if (op_valid && upd_dc) begin
			dc_ff <= dc_new;
		end else if (bus_wr && bus_addr == OFF_STATUS) begin
			dc_ff <= flag_dc;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			z_ff <= FLAG_RST;
		end else if (op_valid && upd_z) begin
			z_ff <= z_new;
		end else if (bus_wr && bus_addr == OFF_STATUS) begin
			z_ff <= flag_z;
		end
	end

	// direction registers; other operand values are ignored
	always_ff @(posedge mclk) begin
		if (srst) begin
			dir_a_ff <= DIR_RST;
		end else if (op_valid && op_code == OP_DIR_LOAD
			&& op_addr == DIR_SEL_A) begin
			dir_a_ff <= acc_ff;
		end else if (bus_wr && bus_addr == OFF_DIR_A) begin
			dir_a_ff <= bus_wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			dir_b_ff <= DIR_RST;
		end else if (op_valid && op_code == OP_DIR_LOAD
			&& op_addr == DIR_SEL_B) begin
			dir_b_ff <= acc_ff;
		end else if (bus_wr && bus_addr == OFF_DIR_B) begin
			dir_b_ff <= bus_wdata;
		end
	end

	// completion pulse, one cycle after each accepted instruction
	always_ff @(posedge mclk) begin
		if (srst) begin
			done_ff <= 1'b0;
		end else begin
			done_ff <= op_valid;
		end
	end

	// status image, unused bits read as zero
	always_comb begin
		status_rd              = 8'h00;
		status_rd[STAT_C_BIT]  = c_ff;
		status_rd[STAT_DC_BIT] = dc_ff;
		status_rd[STAT_Z_BIT]  = z_ff;
	end

	// read data: valid the cycle after the strobe, zero otherwise
	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata_ff <= 8'h00;
		end else if (bus_rd) begin
			if (is_file_addr(bus_addr)) begin
				rdata_ff <= file_mem_ff[file_index(bus_addr)];
			end else if (bus_addr == OFF_ACC) begin
				rdata_ff <= acc_ff;
			end else if (bus_addr == OFF_STATUS) begin
				rdata_ff <= status_rd;
			end else if (bus_addr == OFF_DIR_A) begin
				rdata_ff <= dir_a_ff;
			end else if (bus_addr == OFF_DIR_B) begin
				rdata_ff <= dir_b_ff;
			end else begin
				rdata_ff <= 8'h00; // unmapped
			end
		end else begin
			rdata_ff <= 8'h00;
		end
	end

	// outputs straight from flip-flops
	assign bus_rdata        = rdata_ff;
	assign op_done          = done_ff;
	assign acc_out          = acc_ff;
	assign carry_flag       = c_ff;
	assign digit_carry_flag = dc_ff;
	assign zero_flag        = z_ff;
	assign port_direction_a = dir_a_ff;
	assign port_direction_b = dir_b_ff;

	// checks on the datapath
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);

	sequence issue_s(bau_op_t o, logic d);
		op_valid && op_code == o && op_dest == d;
	endsequence

	sequence flags_hold_s;
		##1 dc_ff == $past(dc_ff) && z_ff == $past(z_ff);
	endsequence

	rotl_to_acc_a: assert property (
		issue_s(OP_ROTATE_LEFT, 1'b0) |=>
		acc_ff == {$past(src[6:0]), $past(c_ff)} && c_ff == $past(src[7]))
		else $error("rotate left into acc wrong");

	rotl_flags_a: assert property (
		op_valid && op_code == OP_ROTATE_LEFT |-> flags_hold_s)
		else $error("rotate left touched dc or z");

	rotr_to_file_a: assert property (
		issue_s(OP_ROTATE_RIGHT, 1'b1) |=>
		file_mem_ff[$past(op_addr)] == {$past(c_ff), $past(src[7:1])}
		&& c_ff == $past(src[0]) && acc_ff == $past(acc_ff)
		&& dc_ff == $past(dc_ff) && z_ff == $past(z_ff))
		else $error("rotate right into file wrong");

	dest_file_a: assert property (
		op_valid && op_dest && op_code != OP_XOR_IMMEDIATE
		&& op_code != OP_DIR_LOAD |=> acc_ff == $past(acc_ff))
		else $error("acc changed on file destination");

	sub_result_a: assert property (
		issue_s(OP_SUB_ACC_FROM_REG, 1'b0) |=>
		acc_ff == 8'($past(src) - $past(acc_ff))
		&& z_ff == (acc_ff == 8'h00))
		else $error("subtract result or zero wrong");

	sub_borrow_a: assert property (
		op_valid && op_code == OP_SUB_ACC_FROM_REG |=>
		c_ff == ($past(src) >= $past(acc_ff))
		&& dc_ff == ($past(src[3:0]) >= $past(acc_ff[3:0])))
		else $error("subtract carry or digit carry wrong");

	swap_nibble_a: assert property (
		issue_s(OP_NIBBLE_EXCHANGE, 1'b0) |=>
		acc_ff == {$past(src[3:0]), $past(src[7:4])}
		&& $stable(c_ff) && $stable(dc_ff) && $stable(z_ff))
		else $error("nibble exchange wrong");

	dir_load_a: assert property (
		op_valid && op_code == OP_DIR_LOAD && op_addr == DIR_SEL_B |=>
		dir_b_ff == $past(acc_ff) && $stable(c_ff) && $stable(z_ff))
		else $error("direction load wrong");

	xor_lit_a: assert property (
		op_valid && op_code == OP_XOR_IMMEDIATE |=>
		acc_ff == ($past(acc_ff) ^ $past(op_lit)) && $stable(c_ff))
		else $error("xor immediate wrong");

	xor_reg_a: assert property (
		issue_s(OP_XOR_REGISTER, 1'b1) |=>
		file_mem_ff[$past(op_addr)] == ($past(acc_ff) ^ $past(src))
		&& z_ff == (file_mem_ff[$past(op_addr)] == 8'h00)
		&& $stable(c_ff) && $stable(dc_ff))
		else $error("xor register wrong");
endmodule // bau_alu_top
`default_nettype wire

// [design/bau_pkg.sv]
package bau_pkg;
	localparam int DATA_W     = 8;
	localparam int FADDR_W    = 5;
	localparam int FILE_DEPTH = 32;
	localparam int BUS_ADDR_W = 6;

	// register bus map
	localparam logic [5:0] OFF_FILE_BASE = 6'h00;
	localparam logic [5:0] OFF_ACC       = 6'h20;
	localparam logic [5:0] OFF_STATUS    = 6'h21;
	localparam logic [5:0] OFF_DIR_A     = 6'h22;
	localparam logic [5:0] OFF_DIR_B     = 6'h23;

	// status register bit positions
	localparam int STAT_C_BIT  = 0;
	localparam int STAT_DC_BIT = 1;
	localparam int STAT_Z_BIT  = 2;

	// operand values that select a direction register
	localparam logic [4:0] DIR_SEL_A = 5'h06;
	localparam logic [4:0] DIR_SEL_B = 5'h07;

	// reset values
	localparam logic [7:0] ACC_RST  = 8'h00;
	localparam logic [7:0] FILE_RST = 8'h00;
	localparam logic [7:0] DIR_RST  = 8'hFF;
	localparam logic       FLAG_RST = 1'b0;

	typedef enum logic [2:0] {
		OP_ROTATE_LEFT,
		OP_ROTATE_RIGHT,
		OP_SUB_ACC_FROM_REG,
		OP_NIBBLE_EXCHANGE,
		OP_XOR_REGISTER,
		OP_XOR_IMMEDIATE,
		OP_DIR_LOAD
	} bau_op_t;
endpackage

// [design/bau_exec_unit.sv]
`timescale 1ns/1ps
`default_nettype none
module bau_exec_unit (
	// operation and operands
	input  wire bau_pkg::bau_op_t op,
	input  wire logic [7:0]       src,
	input  wire logic [7:0]       acc,
	input  wire logic [7:0]       lit,
	input  wire logic             carry_in,
	// result and flag updates
	output logic [7:0]            res,
	output logic                  res_valid,
	output logic                  c_out,
	output logic                  dc_out,
	output logic                  z_out,
	output logic                  upd_c,
	output logic                  upd_dc,
	output logic                  upd_z
);
	import bau_pkg::*;

	logic [8:0] diff_full;
	logic [4:0] diff_low;

	// adding the inverted accumulator plus one gives carry = no borrow
	assign diff_full = {1'b0, src} + {1'b0, ~acc} + 9'h001;
	assign diff_low  = {1'b0, src[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;

	// result and flag selection per operation
	always_comb begin
		res       = 8'h00;
		res_valid = 1'b1;
		c_out     = 1'b0;
		dc_out    = 1'b0;
		z_out     = 1'b0;
		upd_c     = 1'b0;
		upd_dc    = 1'b0;
		upd_z     = 1'b0;
		unique case (op)
			OP_ROTATE_LEFT: begin
				res   = {src[6:0], carry_in};
				c_out = src[7];
				upd_c = 1'b1;
			end
			OP_ROTATE_RIGHT: begin
				res   = {carry_in, src[7:1]};
				c_out = src[0];
				upd_c = 1'b1;
			end
			OP_SUB_ACC_FROM_REG: begin
				res    = diff_full[7:0];
				c_out  = diff_full[8];
				dc_out = diff_low[4];
				z_out  = (diff_full[7:0] == 8'h00);
				upd_c  = 1'b1;
				upd_dc = 1'b1;
				upd_z  = 1'b1;
			end
			OP_NIBBLE_EXCHANGE: begin
				res = {src[3:0], src[7:4]};
			end
			OP_XOR_REGISTER: begin
				res   = acc ^ src;
				z_out = ((acc ^ src) == 8'h00);
				upd_z = 1'b1;
			end
			OP_XOR_IMMEDIATE: begin
				res = acc ^ lit;
			end
			OP_DIR_LOAD: begin
				// no data result, the top copies the accumulator itself
				res_valid = 1'b0;
			end
			default: begin
				// a 3-bit code can hold an unused value
				res_valid = 1'b0;
			end
		endcase
	end
endmodule // bau_exec_unit
`default_nettype wire

// [tb/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import bau_pkg::*;
	// design ports
	logic       mclk, srst, op_valid, op_dest, bus_wr, bus_rd;
	bau_op_t    op_code;
	logic [4:0] op_addr;
	logic [5:0] bus_addr;
	logic [7:0] op_lit, bus_wdata, bus_rdata, acc_out, dir_a, dir_b;
	logic       op_done, c_flag, dc_flag, z_flag;
	// reference state and expectation queues
	logic [7:0]  m_file [32];
	logic [7:0]  m_acc, m_da, m_db, rnd;
	logic        m_c, m_dc, m_z, rd_pend_ff;
	logic [26:0] q_op[$];
	logic [7:0]  q_rd[$];
	int          miscompares, compares;
	// subtract borrow corner operands, file value and accumulator
	logic [7:0]  sub_f [5] = '{8'h10, 8'h10, 8'h01, 8'h00, 8'h80};
	logic [7:0]  sub_w [5] = '{8'h10, 8'h01, 8'h02, 8'h00, 8'h7F};
	logic [26:0] st_seen;

	bau_alu_top dut (.mclk(mclk), .srst(srst), .op_valid(op_valid),
		.op_code(op_code), .op_addr(op_addr), .op_dest(op_dest),
		.op_lit(op_lit), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
		.bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.op_done(op_done), .acc_out(acc_out), .carry_flag(c_flag),
		.digit_carry_flag(dc_flag), .zero_flag(z_flag),
		.port_direction_a(dir_a), .port_direction_b(dir_b));

	// observed state, packed like the notes in q_op
	assign st_seen = {acc_out, c_flag, dc_flag, z_flag, dir_a, dir_b};

	always #4 mclk = ~mclk;

	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction

	function automatic logic [7:0] model_read(input logic [5:0] a);
		if (a < OFF_ACC) return m_file[a[4:0]];
		case (a)
		OFF_ACC:    return m_acc;
		OFF_STATUS: return {5'h00, m_z, m_dc, m_c};
		OFF_DIR_A:  return m_da;
		OFF_DIR_B:  return m_db;
		default:    return 8'h00;
		endcase
	endfunction

	task automatic check(string what, logic [26:0] exp, logic [26:0] got);
		compares++;
		if (got !== exp) begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	// monitor: oldest note against each result as it appears
	always @(posedge mclk) begin
		rd_pend_ff <= bus_rd & ~srst;
		if (op_done === 1'b1)
			check("state", q_op.pop_front(), st_seen);
		if (rd_pend_ff === 1'b1)
			check("bus_rdata", 27'(q_rd.pop_front()), 27'(bus_rdata));
	end

	task automatic bwr(logic [5:0] a, logic [7:0] d);
		@(posedge mclk);
		op_valid  <= 1'b0;
		bus_rd    <= 1'b0;
		bus_wr    <= 1'b1;
		bus_addr  <= a;
		bus_wdata <= d;
		if (a < OFF_ACC) m_file[a[4:0]] = d;
		else if (a == OFF_ACC) m_acc = d;
		else if (a == OFF_STATUS) {m_z, m_dc, m_c} = d[2:0];
		else if (a == OFF_DIR_A) m_da = d;
		else if (a == OFF_DIR_B) m_db = d;
	endtask

	task automatic brd(logic [5:0] a);
		@(posedge mclk);
		op_valid <= 1'b0;
		bus_wr   <= 1'b0;
		bus_rd   <= 1'b1;
		bus_addr <= a;
		q_rd.push_back(model_read(a));
	endtask

	task automatic idle();
		@(posedge mclk);
		op_valid <= 1'b0;
		bus_wr   <= 1'b0;
		bus_rd   <= 1'b0;
	endtask

	// one instruction; the model sees the previous one's result
	task automatic op(bau_op_t c, logic [4:0] a, logic d, logic [7:0] k);
		logic [7:0] s, r;
		logic       wb;
		@(posedge mclk);
		bus_wr   <= 1'b0;
		bus_rd   <= 1'b0;
		op_valid <= 1'b1;
		op_code  <= c;
		op_addr  <= a;
		op_dest  <= d;
		op_lit   <= k;
		s = m_file[a];
		r = s;
		wb = 1'b1;
		case (c)
		OP_ROTATE_LEFT: begin
			r = {s[6:0], m_c};
			m_c = s[7];
		end
		OP_ROTATE_RIGHT: begin
			r = {m_c, s[7:1]};
			m_c = s[0];
		end
		OP_SUB_ACC_FROM_REG: begin
			r = s - m_acc;
			m_c = s >= m_acc;
			m_dc = s[3:0] >= m_acc[3:0];
			m_z = r == 8'h00;
		end
		OP_NIBBLE_EXCHANGE: r = {s[3:0], s[7:4]};
		OP_XOR_REGISTER: begin
			r = m_acc ^ s;
			m_z = r == 8'h00;
		end
		OP_XOR_IMMEDIATE: begin
			m_acc = m_acc ^ k;
			wb = 1'b0;
		end
		default: begin
			wb = 1'b0;
			if (a == DIR_SEL_A) m_da = m_acc;
			else if (a == DIR_SEL_B) m_db = m_acc;
		end
		endcase
		if (wb && d) m_file[a] = r;
		else if (wb) m_acc = r;
		q_op.push_back({m_acc, m_c, m_dc, m_z, m_da, m_db});
	endtask

	task automatic finish_test();
		// a missing op_done or read pulse leaves notes behind
		check("pending", 27'h0, 27'(q_op.size() + q_rd.size()));
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// watchdog, far beyond the roughly 180 cycles the tests need
	initial begin
		repeat (3000) @(posedge mclk);
		miscompares++;
		$display("watchdog expired");
		finish_test();
	end

	initial begin
		{mclk, op_valid, op_dest, bus_wr, bus_rd} = 5'h00;
		srst = 1'b1;
		op_code = OP_ROTATE_LEFT;
		{op_addr, bus_addr, op_lit, bus_wdata} = 27'h0;
		{m_acc, m_c, m_dc, m_z, m_da, m_db} = {8'h00, 3'h0, DIR_RST, DIR_RST};
		foreach (m_file[i]) m_file[i] = FILE_RST;
		{miscompares, compares} = 0;
		rnd = 8'h1F;
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		// reset values, unmapped read gives zero
		for (int i = 32; i < 36; i++) brd(6'(i));
		brd(6'h05);
		brd(6'h3F);
		$display("test reset_values done");
		// preload file, write then read back to back
		for (int i = 0; i < 32; i++) begin
			rnd = lfsr(rnd);
			bwr(6'(i), rnd);
		end
		bwr(OFF_DIR_A, 8'h5A);
		brd(OFF_DIR_A);
		bwr(OFF_STATUS, 8'h01);
		op(OP_ROTATE_LEFT, 5'h03, 1'b1, 8'h00);
		op(OP_ROTATE_RIGHT, 5'h03, 1'b0, 8'h00);
		$display("test bus_and_carry done");
		// subtract borrow boundaries
		for (int i = 0; i < 5; i++) begin
			bwr(6'h03, sub_f[i]);
			bwr(OFF_ACC, sub_w[i]);
			op(OP_SUB_ACC_FROM_REG, 5'h03, i[0], 8'h00);
		end
		$display("test subtract_bounds done");
		// every code with both destinations, back to back
		for (int c = 0; c < 7; c++) begin
			for (int d = 0; d < 2; d++) begin
				rnd = lfsr(rnd);
				op(bau_op_t'(3'(c)), (c == 6) ? 5'(6 + d) : rnd[4:0],
					d[0], rnd);
			end
		end
		op(OP_DIR_LOAD, 5'h09, 1'b0, 8'h00);
		$display("test all_codes done");
		// random stream, then read back the whole map
		for (int i = 0; i < 60; i++) begin
			rnd = lfsr(rnd);
			op(bau_op_t'(3'(rnd % 8'h07)), rnd[4:0], rnd[5], lfsr(rnd));
		end
		for (int i = 0; i < 36; i++) brd(6'(i));
		repeat (3) idle();
		$display("test random_stream done");
		finish_test();
	end
endmodule // testbench
`default_nettype wire
